// ---- logic/eeo_pkg.sv ----
// Purpose: Constants and types shared by the encoder emulation output block
// Assumes: 32-bit AHB-Lite register access, 25 MHz system clock
// Notes: Register offsets are byte addresses of aligned words
package eeo_pkg;
  localparam logic [7:0] EEO_OFS_CTRL = 8'h00;
  localparam logic [7:0] EEO_OFS_LINES = 8'h04;
  localparam logic [7:0] EEO_OFS_OFFSET = 8'h08;
  localparam logic [7:0] EEO_OFS_INTERP = 8'h0C;
  localparam logic [7:0] EEO_OFS_STATUS = 8'h10;
  localparam logic [7:0] EEO_OFS_POS = 8'h14;
  // Control register fields
  localparam int EEO_CTRL_MODE_LSB = 0;
  localparam int EEO_CTRL_MULTI_BIT = 2;
  localparam int EEO_CTRL_BINARY_BIT = 3;
  localparam int EEO_CTRL_FAST_BIT = 4;
  localparam int EEO_CTRL_INVCLK_BIT = 5;
  localparam int EEO_CTRL_REVERSE_BIT = 6;
  localparam int EEO_CTRL_COMTRK_BIT = 7;
  localparam int EEO_CTRL_HOMED_BIT = 8;
  localparam int EEO_CTRL_POLES_LSB = 9;
  localparam logic [31:0] EEO_CTRL_RESET = 32'h0000_0001;
  localparam logic [19:0] EEO_LINES_RESET = 20'h00400;
  localparam logic [19:0] EEO_LINES_MIN = 20'h00100;
  localparam logic [19:0] EEO_LINES_MAX_ENC = 20'h80000;
  localparam logic [19:0] EEO_LINES_MAX_RES = 20'h01000;
  localparam logic [2:0] EEO_INTERP_MIN = 3'h2;
  localparam logic [2:0] EEO_INTERP_MAX = 3'h7;
  localparam logic [1:0] EEO_MODE_QUAD = 2'h1;
  localparam logic [1:0] EEO_MODE_SSI = 2'h2;
  localparam logic [1:0] EEO_MODE_INTERP = 2'h3;
  localparam int EEO_FRAME_BITS = 24;
  localparam int EEO_CLK_HZ = 25_000_000;
  // Monoflop pause of the serial link
  localparam int EEO_PAUSE_NS = 20_000;
  localparam int EEO_PAUSE_CYC = (EEO_PAUSE_NS * (EEO_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int EEO_STEP_NS = 2_000;
  localparam int EEO_STEP_CYC = EEO_STEP_NS * (EEO_CLK_HZ / 1_000_000) / 1000;
  typedef enum logic [1:0] {EEO_IDLE, EEO_SHIFT, EEO_PAUSE} eeo_ssi_t;
endpackage

// ---- logic/eeo_top.sv ----
// Purpose: Encoder emulation output, quadrature or serial absolute frame
// Assumes: Position word and serial clock arrive from outside the hclk domain
// Notes: Serial clock is sampled by hclk; edges found after two flip-flops
// Operation
// - Derive shaft position from cyclic absolute feedback; make incremental pulses.
// - Drive A and B a quarter period apart; zero pulse once per turn at A=B=1.
// - Programmable line count, up to 524288 with encoder, 4096 with resolver.
// - Select value 3 drives A=B=0, since fine position shifted left by 2 to 7 bits leaves bits 1:0 zero; analog zero through.
// - Zero pulse angle within a turn set by a stored offset.
// - Position counts up for clockwise shaft rotation by default.
// - Serial mode sends each position word as a 24-bit frame.
// - Single-turn layout zeroes upper 12 bits, position in lower 12.
// - 12-bit single-turn value spans a turn divided by resolver pole pairs.
// - Commutation-track encoder sets upper 12 bits to one until homed.
// - Multi-turn layout carries turn count high, position low.
// - Frame is Gray coded by default, binary when selected.
// - Serial clock of either polarity is selectable; its rate is set by the master, the fast bit is not decoded.
`timescale 1ns/1ps
module eeo_top
  import eeo_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] fb_angle,
  input wire logic [11:0] fb_turns,
  input wire logic [18:0] fb_fine,
  input wire logic fb_sine_zero,
  input wire logic serial_clk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_zero,
  output logic serial_data
);
  import eeo_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [19:0] lines;
    logic [18:0] offset;
    logic [2:0] interp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [11:0] ang_s1, ang_s2, trn_s1, trn_s2;
    logic [18:0] fine_s1, fine_s2;
    logic zin_s1, zin_s2;
    logic sclk_s1, sclk_s2, sclk_d;
    logic [20:0] acc;
    logic [18:0] prev_fine;
    logic [1:0] quad;
    logic a, b, z, sd;
    eeo_ssi_t st;
    logic [23:0] frame;
    logic [4:0] bitcnt;
    logic [15:0] pause;
  } eeo_state_t;

  eeo_state_t s, n;

  function automatic logic [23:0] eeo_gray(input logic [23:0] v);
    return v ^ (v >> 1);
  endfunction

  function automatic logic [2:0] eeo_pairs(input logic [1:0] p);
    return (p == 2'h0) ? 3'h1 : {1'b0, p};
  endfunction

  logic [1:0] mode;
  logic [18:0] pos, rel;
  logic [19:0] lim_lines;
  logic [11:0] st_pos;
  logic [23:0] word;
  logic sclk_rise, sclk_fall, lead_edge, trail_edge;
  logic [39:0] prod;
  logic [19:0] step;

  always_comb begin
    mode = s.ctrl[EEO_CTRL_MODE_LSB +: 2];
    // Shaft position as the emulation sees it; reverse flips direction
    pos = s.ctrl[EEO_CTRL_REVERSE_BIT] ? (19'h0 - s.fine_s2) : s.fine_s2;
    rel = pos - s.offset;
    lim_lines = s.ctrl[EEO_CTRL_COMTRK_BIT] ? EEO_LINES_MAX_ENC : EEO_LINES_MAX_RES;
    // Electrical angle per pole pair in single-turn
    st_pos = 12'(s.ang_s2 * eeo_pairs(s.ctrl[EEO_CTRL_POLES_LSB +: 2]));
    if (s.ctrl[EEO_CTRL_MULTI_BIT])
      word = {s.trn_s2, s.ang_s2};
    else if (s.ctrl[EEO_CTRL_COMTRK_BIT] && !s.ctrl[EEO_CTRL_HOMED_BIT])
      word = {12'hFFF, st_pos};
    else
      word = {12'h000, st_pos};
    if (!s.ctrl[EEO_CTRL_BINARY_BIT])
      word = eeo_gray(word);
    sclk_rise = s.sclk_s2 & ~s.sclk_d;
    sclk_fall = ~s.sclk_s2 & s.sclk_d;
    lead_edge = s.ctrl[EEO_CTRL_INVCLK_BIT] ? sclk_rise : sclk_fall;
    trail_edge = s.ctrl[EEO_CTRL_INVCLK_BIT] ? sclk_fall : sclk_rise;
    // Quarter-line steps per revolution: 4*lines over 2^19 counts
    prod = 40'(rel) * 40'({s.lines, 2'b00});
    step = prod[38:19];
  end

  always_comb begin
    n = s;
    n.ang_s1 = fb_angle;
    n.ang_s2 = s.ang_s1;
    n.trn_s1 = fb_turns;
    n.trn_s2 = s.trn_s1;
    n.fine_s1 = fb_fine;
    n.fine_s2 = s.fine_s1;
    n.zin_s1 = fb_sine_zero;
    n.zin_s2 = s.zin_s1;
    n.sclk_s1 = serial_clk;
    n.sclk_s2 = s.sclk_s1;
    n.sclk_d = s.sclk_s2;
    // Bus write data phase
    if (s.wr_pend) begin
      n.wr_pend = 1'b0;
      unique case (s.wr_addr)
        EEO_OFS_CTRL: n.ctrl = hwdata;
        EEO_OFS_LINES: begin
          if (hwdata[19:0] < EEO_LINES_MIN)
            n.lines = EEO_LINES_MIN;
          else if (hwdata[19:0] > lim_lines)
            n.lines = lim_lines;
          else
            n.lines = hwdata[19:0];
        end
        EEO_OFS_OFFSET: n.offset = hwdata[18:0];
        EEO_OFS_INTERP: begin
          if (hwdata[2:0] < EEO_INTERP_MIN)
            n.interp = EEO_INTERP_MIN;
          else
            n.interp = hwdata[2:0];
        end
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      n.wr_pend = hwrite;
      n.wr_addr = haddr[7:0];
      unique case (haddr[7:0])
        EEO_OFS_CTRL: n.rdata = s.ctrl;
        EEO_OFS_LINES: n.rdata = {12'h000, s.lines};
        EEO_OFS_OFFSET: n.rdata = {13'h0000, s.offset};
        EEO_OFS_INTERP: n.rdata = {29'h0, s.interp};
        EEO_OFS_STATUS: n.rdata = {24'h0, 2'h0, s.st == EEO_SHIFT, s.z, s.b, s.a, mode};
        EEO_OFS_POS: n.rdata = {8'h00, word};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Quadrature: walk the Gray-coded AB state toward the target step
    if (mode == EEO_MODE_QUAD || mode == EEO_MODE_INTERP) begin
      if (mode == EEO_MODE_INTERP)
        n.acc = 21'(s.prev_fine) << s.interp;
      else
        n.acc = {1'b0, step};
      if (n.acc[1:0] != s.quad) begin
        if (n.acc[1:0] - s.quad == 2'h1 || n.acc[1:0] - s.quad == 2'h2)
          n.quad = s.quad + 2'h1;
        else
          n.quad = s.quad - 2'h1;
      end
      n.prev_fine = pos;
      n.a = (n.quad == 2'h1) || (n.quad == 2'h2);
      n.b = n.quad[1];
      if (mode == EEO_MODE_INTERP)
        n.z = s.zin_s2;
      else
        n.z = (step[19:2] == 18'h0) && n.a && n.b;
    end else begin
      n.a = 1'b0;
      n.b = 1'b0;
      n.z = 1'b0;
    end
    // Serial frame engine
    unique case (s.st)
      EEO_IDLE: begin
        n.sd = 1'b1;
        if (mode == EEO_MODE_SSI && lead_edge) begin
          // First leading edge both latches the word and puts out its MSB
          n.sd = word[23];
          n.frame = {word[22:0], 1'b0};
          n.bitcnt = 5'(EEO_FRAME_BITS - 1);
          n.st = EEO_SHIFT;
        end
      end
      EEO_SHIFT: begin
        if (lead_edge) begin
          n.sd = s.frame[23];
          n.frame = {s.frame[22:0], 1'b0};
          n.bitcnt = s.bitcnt - 5'h1;
          if (s.bitcnt == 5'h1) begin
            n.st = EEO_PAUSE;
            n.pause = 16'(EEO_PAUSE_CYC);
          end
        end
      end
      EEO_PAUSE: begin
        // Data low until the link has idled a full monoflop time
        if (lead_edge || trail_edge)
          n.pause = 16'(EEO_PAUSE_CYC);
        else if (s.pause != 16'h0)
          n.pause = s.pause - 16'h1;
        else
          n.st = EEO_IDLE;
        if (trail_edge)
          n.sd = 1'b0;
      end
      default: begin
        n.sd = 1'b1;
        n.st = EEO_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ctrl <= EEO_CTRL_RESET;
      s.lines <= EEO_LINES_RESET;
      s.interp <= EEO_INTERP_MIN;
      s.sd <= 1'b1;
      s.st <= EEO_IDLE;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign enc_a = s.a;
  assign enc_b = s.b;
  assign enc_zero = s.z;
  assign serial_data = s.sd;
endmodule

// ---- verif/eeo_top_assertions.sv ----
// Purpose: Port checks for the encoder emulation output
// Assumes: Mode follows bus writes to the control word
// Notes: Serial idle time is counted at the pin
`timescale 1ns/1ps
module eeo_top_assertions
  import eeo_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fb_sine_zero,
  input wire logic serial_clk,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_zero,
  input wire logic serial_data
);
  localparam int P = EEO_PAUSE_CYC;
  logic [1:0] md;
  logic wp, sp;
  logic [9:0] ic;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      md <= 2'h1;
      wp <= 1'b0;
      sp <= 1'b0;
      ic <= 10'h000;
    end else begin
      wp <= htrans[1] && hwrite && haddr[7:0] == 8'h00;
      md <= wp ? hwdata[1:0] : md;
      sp <= serial_clk;
      ic <= (serial_clk != sp) ? 10'h000 : ic + {9'h000, ic != 10'h3FF};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_zup;
    md == 2'h3 && $rose(fb_sine_zero) ##1 fb_sine_zero [*3];
  endsequence
  sequence s_zdn;
    md == 2'h3 && $fell(fb_sine_zero) ##1 !fb_sine_zero [*3];
  endsequence
  a_bus_ready: assert property (hreadyout) else $error("not ready");
  a_bus_okay: assert property (!hresp) else $error("not okay");
  a_ab_apart: assert property (md == 2'h1 |-> !($changed(enc_a) && $changed(enc_b)))
    else $error("A and B moved together");
  a_zero_at_ab: assert property (md == 2'h1 && enc_zero |-> enc_a && enc_b)
    else $error("zero pulse off A=B=1");
  a_zero_pass: assert property (s_zup |-> ##[0:3] enc_zero)
    else $error("zero mark not passed");
  a_zero_drop: assert property (s_zdn |-> ##[0:3] !enc_zero)
    else $error("zero mark stuck");
  a_serial_idle: assert property (ic > P + 10 |-> serial_data)
    else $error("serial idle not high");
  a_data_moves: assert property ($changed(serial_data) |-> ic < 8 || (ic > P - 3 && ic < P + 9))
    else $error("serial data moved");
endmodule
bind eeo_top eeo_top_assertions chk_u(.hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata,
  .hreadyout, .hresp, .fb_sine_zero, .serial_clk, .enc_a, .enc_b, .enc_zero, .serial_data);

// ---- verif/eeo_ssi_master.sv ----
// Purpose: Serial evaluation unit reading absolute frames
// Assumes: Leading edge falls, or rises when inv is set
// Notes: Bits read just before the trailing edge, past the sync delay
`timescale 1ns/1ps
module eeo_ssi_master(
  output logic sclk,
  input wire logic sdata,
  input wire logic inv
);
  logic lvl = 1'b1;
  assign sclk = lvl ^ inv;
  task automatic frame(output logic [23:0] w);
    #25007;
    for (int i = 0; i < 24; i++) begin
      // Sample before the trailing edge: the device drops data low on the last one
      lvl = 1'b0;
      #155 w = {w[22:0], sdata};
      #5 lvl = 1'b1;
      #160;
    end
  endtask
endmodule

// ---- verif/encoder_emulation_output_bench.sv ----
// Purpose: Self-checking bench for the encoder emulation output
// Assumes: Zero wait-state bus
// Notes: Lines cut to 256 so one turn stays short
`timescale 1ns/1ps
module encoder_emulation_output_bench;
  import eeo_pkg::*;
  localparam logic [11:0] A = 12'hABC;
  localparam logic [11:0] T = 12'h5A3;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, inv, fb_sine_zero, serial_clk;
  logic enc_a, enc_b, enc_zero, serial_data, pa = 1'b0, pz = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [11:0] fb_angle = A;
  logic [11:0] fb_turns = T;
  logic [18:0] fb_fine;
  logic [23:0] w, f;
  int errors = 0, n_checks = 0, cyc = 0, na = 0, nz = 0, n0, z0;
  logic [31:0] sc [6] = '{32'h202, 32'h20E, 32'h206, 32'h28A, 32'h38A, 32'h22A};
  logic [31:0] lt [4][3] = '{'{32'h1, 32'h80000, 32'h1000}, '{32'h1, 32'h10, 32'h100},
    '{32'h81, 32'h80000, 32'h80000}, '{32'h201, 32'h100, 32'h100}};
  assign hready = hreadyout;
  eeo_top dut_u(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .fb_angle, .fb_turns, .fb_fine, .fb_sine_zero, .serial_clk, .enc_a, .enc_b,
    .enc_zero, .serial_data);
  eeo_ssi_master p_u(.sclk(serial_clk), .sdata(serial_data), .inv);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    pa <= enc_a;
    pz <= enc_zero;
    if (enc_a === 1'b1 && pa === 1'b0) na++;
    if (enc_zero === 1'b1 && pz === 1'b0) nz++;
    if (cyc == 90000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic stop_test();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, fb_sine_zero, fb_fine, inv} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, EEO_OFS_CTRL, 32'h0);
    chk(rd, EEO_CTRL_RESET);
    bus(1'b0, EEO_OFS_LINES, 32'h0);
    chk(rd, {12'h0, EEO_LINES_RESET});
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    foreach (lt[i]) begin
      bus(1'b1, EEO_OFS_CTRL, lt[i][0]);
      bus(1'b1, EEO_OFS_LINES, lt[i][1]);
      bus(1'b0, EEO_OFS_LINES, 32'h0);
      chk(rd, lt[i][2]);
    end
    n0 = na;
    z0 = nz;
    repeat (1024) begin
      fb_fine <= fb_fine + 19'h200;
      repeat (60) @(posedge hclk);
    end
    repeat (200) @(posedge hclk);
    chk(na - n0, 256);
    chk(nz - z0, 1);
    foreach (sc[i]) begin
      bus(1'b1, EEO_OFS_CTRL, sc[i]);
      inv <= sc[i][5];
      f = sc[i][2] ? {T, A} : {(sc[i][7] && !sc[i][8]) ? 12'hFFF : 12'h0, A};
      fork
        p_u.frame(w);
        begin
          // Disturb the input mid-frame; the latched word must not follow
          repeat (700) @(posedge hclk);
          fb_angle <= ~A;
          repeat (100) @(posedge hclk);
          fb_angle <= A;
        end
      join
      chk({8'h0, w}, {8'h0, sc[i][3] ? f : f ^ (f >> 1)});
    end
    bus(1'b1, EEO_OFS_CTRL, 32'h3);
    fb_sine_zero <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({31'h0, enc_zero}, 32'h1);
    fb_sine_zero <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({31'h0, enc_zero}, 32'h0);
    stop_test();
  end
endmodule
